// file: blm_top.sv
// What this block does
// R1 - Compared value is raw ADC output minus that channel's offset register.
// R2 - Comparison happens only in float LED subtract cycles, never add cycles.
// R3 - Subtract cycles are pulse positions with LED masked: background only.
// R4 - Each slot channel counts subtract cycles where result exceeds threshold.
// R5 - Count-limit code: 0 never, 1 after one, 2 after four, 3 after sixteen.
// R6 - Flag byte: bits 3..0 slot A channels, bits 7..4 slot B channels.
// R7 - Reading the flag register clears every flag bit except one being set in that same cycle.
// R8 - Threshold is bits 13..0 of the slot A and slot B limit registers.
// R9 - Count-limit code is bits 15..14 of those same per-slot registers.
// R10 - Pin 0 select codes route OR of slot A, slot B, all, all plus interrupt.
// R11 - Pin 1 select sits in bits 12..8, same codes, drives pin 1.
// R12 - Host polls flags or watches a pin to retune under bright ambient light.
// R13 - Four-pulse sequence adds pulses two and three, subtracts one and four.
// R14 - Counter clears on flag read and reset, and saturates without wrapping.
`timescale 1ns/10ps
`default_nettype none
`include "blm_cfg.svh"

module blm_top
    import blm_pkg::*;
(
    input wire logic clock, // 20 MHz sample clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic reg_wr, // Write strobe, one cycle
    input wire logic reg_rd, // Read strobe, one cycle
    input wire logic [15:0] reg_wdata, // Write data
    output logic [15:0] reg_rdata, // Read data, valid cycle after strobe
    input wire logic sample_valid, // ADC result strobe, one cycle
    input wire logic sample_slot, // Time slot, 0 = A, 1 = B
    input wire logic [1:0] sample_chan, // Channel 1..4 as 0..3
    input wire logic [1:0] pulse_pos, // Position in the four-pulse sequence
    input wire logic float_led_mode, // Float LED mode active
    input wire blm_adc_t adc_raw, // Raw ADC output
    input wire blm_adc_t adc_offset, // Offset register of this channel
    input wire logic dev_int, // Device interrupt level
    output logic gpio0_alt, // Pin 0 alternate function level
    output logic gpio1_alt // Pin 1 alternate function level
);

    logic rst_meta_r;
    logic rst_sync_r;
    logic rst_sync_n;
    logic [15:0] pinsel_r;
    logic [15:0] pinsel_nxt;
    logic [15:0] lim_a_r;
    logic [15:0] lim_a_nxt;
    logic [15:0] lim_b_r;
    logic [15:0] lim_b_nxt;
    logic [7:0] hit_r;
    logic [7:0] hit_nxt;
    logic [7:0] flags;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic gpio0_r;
    logic gpio0_nxt;
    logic gpio1_r;
    logic gpio1_nxt;
    logic [14:0] diff;
    logic sub_cycle;
    logic exceed;
    logic flags_rd;
    blm_adc_t thr;

    // Reset release through two flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    assign rst_sync_n = rst_sync_r;

    // Register writes
    always_comb begin
        pinsel_nxt = pinsel_r;
        lim_a_nxt = lim_a_r;
        lim_b_nxt = lim_b_r;
        if (reg_wr) begin
            case (reg_addr)
                // R11 pin select fields
                `BLM_OFS_PINSEL: pinsel_nxt = reg_wdata & `BLM_PINSEL_MASK;
                // R8 R9 per-slot limit
                `BLM_OFS_LIM_A: lim_a_nxt = reg_wdata;
                `BLM_OFS_LIM_B: lim_b_nxt = reg_wdata;
                default: pinsel_nxt = pinsel_r;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pinsel_r <= `BLM_RST_PINSEL;
            lim_a_r <= `BLM_RST_LIM;
            lim_b_r <= `BLM_RST_LIM;
        end else begin
            pinsel_r <= pinsel_nxt;
            lim_a_r <= lim_a_nxt;
            lim_b_r <= lim_b_nxt;
        end
    end

    // Offset correction, subtract-cycle gating and compare
    always_comb begin
        // R8 threshold field of the sample's slot
        thr = sample_slot ? lim_b_r[`BLM_THR_HI:`BLM_THR_LO] : lim_a_r[`BLM_THR_HI:`BLM_THR_LO];
        // R1 raw minus offset
        diff = {1'b0, adc_raw} - {1'b0, adc_offset};
        // R2 R3 R13 first and fourth pulses
        sub_cycle = float_led_mode
            && (pulse_pos == `BLM_POS_FIRST || pulse_pos == `BLM_POS_FOURTH);
        exceed = !diff[14] && (diff[13:0] > thr);
        hit_nxt = 8'h00;
        // R4 R6 one bit per slot channel
        if (sample_valid && sub_cycle && exceed) begin
            hit_nxt[{sample_slot, sample_chan}] = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hit_r <= 8'h00;
        end else begin
            hit_r <= hit_nxt;
        end
    end

    // R7 read strobe of the flag register
    assign flags_rd = reg_rd && (reg_addr == `BLM_OFS_FLAGS);

    // One counter and flag per slot channel
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_chan
            blm_chan_counter u_cnt (
                .clock(clock),
                .rst_n(rst_sync_n),
                .hit(hit_r[gi]),
                .clr(flags_rd),
                .limit(blm_limit_e'(gi < 4 ? lim_a_r[`BLM_CNT_HI:`BLM_CNT_LO]
                    : lim_b_r[`BLM_CNT_HI:`BLM_CNT_LO])),
                .flag(flags[gi])
            );
        end
    endgenerate

    // Pin alternate function decode
    function automatic logic alt_level(input blm_altsel_t sel, input logic [7:0] f,
        input logic irq);
        logic lvl;
        lvl = 1'b0;
        case (sel)
            `BLM_ALT_SLOT_A: lvl = |f[3:0];
            `BLM_ALT_SLOT_B: lvl = |f[7:4];
            `BLM_ALT_ALL: lvl = |f;
            `BLM_ALT_ALL_INT: lvl = (|f) | irq;
            default: lvl = 1'b0;
        endcase
        return lvl;
    endfunction

    // Read data and pin levels
    always_comb begin
        // R10 pin 0 select
        gpio0_nxt = alt_level(pinsel_r[`BLM_SEL0_HI:`BLM_SEL0_LO], flags, dev_int);
        // R11 pin 1 select
        gpio1_nxt = alt_level(pinsel_r[`BLM_SEL1_HI:`BLM_SEL1_LO], flags, dev_int);
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            case (reg_addr)
                // R6 flag byte in low bits
                `BLM_OFS_FLAGS: rdata_nxt = {8'h00, flags};
                `BLM_OFS_PINSEL: rdata_nxt = pinsel_r;
                `BLM_OFS_LIM_A: rdata_nxt = lim_a_r;
                `BLM_OFS_LIM_B: rdata_nxt = lim_b_r;
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_r <= 16'h0000;
            gpio0_r <= 1'b0;
            gpio1_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            gpio0_r <= gpio0_nxt;
            gpio1_r <= gpio1_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign gpio0_alt = gpio0_r;
    assign gpio1_alt = gpio1_r;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_sync_n);

    AST_OFFSET_CORR: assert property ( // R1
        sample_valid && float_led_mode && pulse_pos == `BLM_POS_FIRST && !sample_slot
        && adc_raw > adc_offset && (adc_raw - adc_offset) > lim_a_r[13:0]
        |=> hit_r[$past(sample_chan)])
        else $error("corrected result above threshold not counted");
    AST_NOT_ABOVE: assert property ( // R1
        sample_valid && adc_raw <= adc_offset |=> hit_r == 8'h00)
        else $error("non-positive corrected result counted");
    AST_ADD_CYCLE: assert property ( // R2
        (pulse_pos == 2'h1 || pulse_pos == 2'h2) |=> hit_r == 8'h00)
        else $error("add cycle took part in comparison");
    AST_NO_FLOAT: assert property ( // R3
        !float_led_mode |=> hit_r == 8'h00)
        else $error("comparison outside float LED mode");
    AST_RD_FLAGS: assert property ( // R6
        flags_rd |=> reg_rdata == {8'h00, $past(flags)})
        else $error("flag read returned wrong byte");
    AST_RD_CLEARS: assert property ( // R7
        flags_rd && hit_r == 8'h00 |=> flags == 8'h00)
        else $error("flag read did not clear flags");
    AST_LIM_WRITE: assert property ( // R9
        reg_wr && reg_addr == `BLM_OFS_LIM_B |=> lim_b_r == $past(reg_wdata))
        else $error("slot B limit write lost");
    AST_SLOT_B_THR: assert property ( // R8
        sample_valid && sample_slot && adc_raw > adc_offset
        && (adc_raw - adc_offset) <= lim_b_r[13:0] |=> hit_r[7:4] == 4'h0)
        else $error("slot B result at or below its threshold counted");
    AST_PIN0: assert property ( // R10
        pinsel_r[4:0] == `BLM_ALT_SLOT_B |=> gpio0_alt == |$past(flags[7:4]))
        else $error("pin 0 slot B OR wrong");
    AST_PIN1: assert property ( // R11
        pinsel_r[12:8] == `BLM_ALT_ALL_INT ##1 pinsel_r[12:8] == `BLM_ALT_ALL_INT
        |-> gpio1_alt == ((|$past(flags)) | $past(dev_int)))
        else $error("pin 1 OR with interrupt wrong");
    AST_FLAG_ONE: assert property ( // R5
        hit_r[0] && lim_a_r[15:14] == 2'b01 |=> flags[0])
        else $error("limit one did not set flag");

    COV_FLAG_B: cover property (flags[7:4] != 4'h0);
    COV_READ_CLR: cover property (flags_rd && flags != 8'h00);
    COV_PIN0_HIGH: cover property (gpio0_alt);

endmodule
`default_nettype wire

// file: blm_cfg.svh
`ifndef BLM_CFG_SVH
`define BLM_CFG_SVH

// Register offsets on the internal register port
`define BLM_OFS_FLAGS 8'h04
`define BLM_OFS_PINSEL 8'h0b
`define BLM_OFS_LIM_A 8'h16
`define BLM_OFS_LIM_B 8'h1c

// Reset values
`define BLM_RST_PINSEL 16'h0000
`define BLM_RST_LIM 16'h0000
`define BLM_RST_FLAGS 8'h00

// Field positions
`define BLM_THR_HI 13
`define BLM_THR_LO 0
`define BLM_CNT_HI 15
`define BLM_CNT_LO 14
`define BLM_SEL0_HI 4
`define BLM_SEL0_LO 0
`define BLM_SEL1_HI 12
`define BLM_SEL1_LO 8
`define BLM_PINSEL_MASK 16'h1f1f

// Pin alternate select codes
`define BLM_ALT_SLOT_A 5'h10
`define BLM_ALT_SLOT_B 5'h1a
`define BLM_ALT_ALL 5'h1b
`define BLM_ALT_ALL_INT 5'h1c

// Exceedance counts per count-limit code, and counter ceiling
`define BLM_CNT_ONE 5'h01
`define BLM_CNT_FOUR 5'h04
`define BLM_CNT_SIXTEEN 5'h10
`define BLM_CNT_MAX 5'h10

// Subtract positions in the four-pulse float LED sequence
`define BLM_POS_FIRST 2'h0
`define BLM_POS_FOURTH 2'h3

`endif

// file: blm_pkg.sv
package blm_pkg;

    // Count-limit codes
    typedef enum logic [1:0] {
        BLM_LIM_NEVER = 2'b00,
        BLM_LIM_ONE = 2'b01,
        BLM_LIM_FOUR = 2'b10,
        BLM_LIM_SIXTEEN = 2'b11
    } blm_limit_e;

    typedef logic [13:0] blm_adc_t;
    typedef logic [4:0] blm_cnt_t;
    typedef logic [4:0] blm_altsel_t;

endpackage

// file: blm_chan_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "blm_cfg.svh"

module blm_chan_counter
    import blm_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic hit, // Exceedance seen this cycle
    input wire logic clr, // Flag read, clears flag and counter
    input wire blm_limit_e limit, // Count-limit code of the slot
    output logic flag // Sticky background flag
);

    blm_cnt_t cnt_r;
    blm_cnt_t cnt_nxt;
    blm_cnt_t cnt_base;
    blm_cnt_t target;
    logic flag_r;
    logic flag_nxt;
    logic set;

    // Next count, threshold target and sticky flag
    always_comb begin
        // R14 clear on read
        cnt_base = clr ? 5'h00 : cnt_r;
        // R4 R14 saturating count
        cnt_nxt = cnt_base;
        if (hit && cnt_base != `BLM_CNT_MAX) begin
            cnt_nxt = cnt_base + 5'h01;
        end
        // R5 limit code decode
        case (limit)
            BLM_LIM_ONE: target = `BLM_CNT_ONE;
            BLM_LIM_FOUR: target = `BLM_CNT_FOUR;
            BLM_LIM_SIXTEEN: target = `BLM_CNT_SIXTEEN;
            default: target = 5'h00;
        endcase
        set = hit && (limit != BLM_LIM_NEVER) && (cnt_nxt >= target);
        // R7 set wins over clear
        flag_nxt = (flag_r & ~clr) | set;
    end

    // State registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 5'h00;
            flag_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign flag = flag_r;

    // Checker helper: exceedances seen since the last read while the code stays at four
    logic [2:0] four_seen_r;
    logic [2:0] four_seen_nxt;
    always_comb begin
        four_seen_nxt = four_seen_r;
        if (clr || limit != BLM_LIM_FOUR) begin
            four_seen_nxt = {2'h0, hit && (limit == BLM_LIM_FOUR)};
        end else if (hit && four_seen_r != 3'h4) begin
            four_seen_nxt = four_seen_r + 3'h1;
        end
    end

    // Checker helper register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            four_seen_r <= 3'h0;
        end else begin
            four_seen_r <= four_seen_nxt;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_NEVER_SETS: assert property ( // R5
        (limit == BLM_LIM_NEVER) && !flag_r |=> !flag_r)
        else $error("flag set with limit code never");
    AST_FLAG_CAUSE: assert property ( // R4
        $rose(flag_r) |-> $past(hit))
        else $error("flag rose without an exceedance");
    AST_CNT_SAT: assert property ( // R14
        cnt_r <= `BLM_CNT_MAX)
        else $error("counter passed its ceiling");
    AST_CLR_CNT: assert property ( // R14
        clr |=> cnt_r == {4'h0, $past(hit)})
        else $error("counter not restarted by read");
    AST_FOUR_HITS: assert property ( // R5
        four_seen_r == 3'h4 |-> flag_r)
        else $error("flag not set after four exceedances");

    COV_SATURATE: cover property (cnt_r == `BLM_CNT_MAX);

endmodule
`default_nettype wire

// file: blm_afe_model.sv
`timescale 1ns/10ps
`default_nettype none

module blm_afe_model
    import blm_pkg::*;
(
    input wire logic clock, // Sample clock
    output logic sample_valid, // Result strobe
    output logic sample_slot, // Time slot
    output logic [1:0] sample_chan, // Channel index
    output logic [1:0] pulse_pos, // Pulse position
    output logic float_led_mode, // Float LED mode level
    output blm_adc_t adc_raw, // Raw result
    output blm_adc_t adc_offset // Channel offset
);
    // Idle levels at time zero
    initial begin
        sample_valid = 1'b0;
        sample_slot = 1'b0;
        sample_chan = 2'h0;
        pulse_pos = 2'h0;
        float_led_mode = 1'b1;
        adc_raw = 14'h0000;
        adc_offset = 14'h0000;
    end

    // Mode change on a clock edge
    task automatic set_mode(input logic m);
        @(posedge clock);
        float_led_mode <= m;
    endtask

    // One result strobe; data lines scrambled once it has gone
    task automatic send(input logic s, input logic [1:0] ch, input logic [1:0] pos,
                        input blm_adc_t raw, input blm_adc_t off);
        @(posedge clock);
        sample_valid <= 1'b1;
        sample_slot <= s;
        sample_chan <= ch;
        pulse_pos <= pos;
        adc_raw <= raw;
        adc_offset <= off;
        @(posedge clock);
        sample_valid <= 1'b0;
        sample_slot <= ~s;
        sample_chan <= ~ch;
        adc_raw <= ~raw;
        adc_offset <= ~off;
    endtask

    // One strobe at each of the four pulse positions, same result every time
    task automatic frame(input logic s, input logic [1:0] ch, input blm_adc_t raw,
                         input blm_adc_t off);
        for (int p = 0; p < 4; p++) begin
            send(s, ch, p[1:0], raw, off);
        end
    endtask
endmodule

`default_nettype wire

// file: tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "blm_cfg.svh"

module tb;
    import blm_pkg::*;
    logic clock;
    logic rst_n;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic sample_valid;
    logic sample_slot;
    logic [1:0] sample_chan;
    logic [1:0] pulse_pos;
    logic float_led_mode;
    blm_adc_t adc_raw;
    blm_adc_t adc_offset;
    logic dev_int;
    logic gpio0_alt;
    logic gpio1_alt;
    int fail_count = 0;
    int check_count = 0;
    logic [4:0] codes [5] = '{5'h10, 5'h1a, 5'h1b, 5'h1c, 5'h05};
    logic exp_pin [2][5] = '{'{1'b0, 1'b1, 1'b1, 1'b1, 1'b0}, '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0}};

    blm_top i_dut(.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sample_valid(sample_valid), .sample_slot(sample_slot), .sample_chan(sample_chan),
        .pulse_pos(pulse_pos), .float_led_mode(float_led_mode), .adc_raw(adc_raw),
        .adc_offset(adc_offset), .dev_int(dev_int), .gpio0_alt(gpio0_alt),
        .gpio1_alt(gpio1_alt));

    blm_afe_model i_src(.clock(clock), .sample_valid(sample_valid), .sample_slot(sample_slot),
        .sample_chan(sample_chan), .pulse_pos(pulse_pos), .float_led_mode(float_led_mode),
        .adc_raw(adc_raw), .adc_offset(adc_offset));

    // Clock, 50 ns period
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Read strobe, then take the held read data a cycle later
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        #1 check(name, reg_rdata, exp);
    endtask

    // Let hit, flag and pin stages land
    task automatic settle;
        repeat (4) @(posedge clock);
        #1;
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
        dev_int = 1'b0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd_chk("pinsel", `BLM_OFS_PINSEL, `BLM_RST_PINSEL);
        rd_chk("lim_a", `BLM_OFS_LIM_A, `BLM_RST_LIM);
        rd_chk("lim_b", `BLM_OFS_LIM_B, `BLM_RST_LIM);
        reg_write(`BLM_OFS_PINSEL, 16'hffff);
        rd_chk("pinsel", `BLM_OFS_PINSEL, `BLM_PINSEL_MASK);
        reg_write(8'h20, 16'hffff);
        rd_chk("unmapped", 8'h20, 16'h0000);
        reg_write(`BLM_OFS_FLAGS, 16'hffff);
        rd_chk("flags", `BLM_OFS_FLAGS, 16'h0000);
        $display("test registers done");
        // Limit one on slot A, boundary and refused samples first
        reg_write(`BLM_OFS_LIM_A, 16'h4059);
        i_src.send(1'b0, 2'h0, 2'h0, 14'h0063, 14'h000a);
        i_src.send(1'b0, 2'h1, 2'h0, 14'h0005, 14'h0010);
        i_src.send(1'b0, 2'h3, 2'h1, 14'h0064, 14'h000a);
        i_src.send(1'b0, 2'h3, 2'h2, 14'h0064, 14'h000a);
        i_src.set_mode(1'b0);
        i_src.send(1'b0, 2'h3, 2'h0, 14'h0064, 14'h000a);
        i_src.set_mode(1'b1);
        i_src.send(1'b0, 2'h2, 2'h3, 14'h0064, 14'h000a);
        settle();
        rd_chk("flags", `BLM_OFS_FLAGS, 16'h0004);
        rd_chk("flags", `BLM_OFS_FLAGS, 16'h0000);
        $display("test limit one done");
        // Limit four on slot B channel 4, pin 0 on slot B
        reg_write(`BLM_OFS_PINSEL, 16'h001a);
        reg_write(`BLM_OFS_LIM_B, 16'h8059);
        for (int r = 0; r < 2; r++) begin
            i_src.frame(1'b1, 2'h3, 14'h0064, 14'h000a);
            i_src.send(1'b1, 2'h3, 2'h0, 14'h0064, 14'h000a);
            settle();
            check("gpio0", {15'h0000, gpio0_alt}, 16'h0000);
            rd_chk("flags", `BLM_OFS_FLAGS, 16'h0000);
        end
        i_src.frame(1'b1, 2'h3, 14'h0064, 14'h000a);
        i_src.frame(1'b1, 2'h3, 14'h0064, 14'h000a);
        settle();
        check("gpio0", {15'h0000, gpio0_alt}, 16'h0001);
        rd_chk("flags", `BLM_OFS_FLAGS, 16'h0080);
        settle();
        check("gpio0", {15'h0000, gpio0_alt}, 16'h0000);
        $display("test limit four done");
        // Limit sixteen on slot A channel 1, pin 1 on slot A
        reg_write(`BLM_OFS_PINSEL, 16'h1000);
        reg_write(`BLM_OFS_LIM_A, 16'hc059);
        for (int k = 0; k < 7; k++) i_src.frame(1'b0, 2'h0, 14'h0064, 14'h000a);
        i_src.send(1'b0, 2'h0, 2'h0, 14'h0064, 14'h000a);
        settle();
        check("gpio1", {15'h0000, gpio1_alt}, 16'h0000);
        i_src.send(1'b0, 2'h0, 2'h3, 14'h0064, 14'h000a);
        settle();
        check("gpio1", {15'h0000, gpio1_alt}, 16'h0001);
        for (int k = 0; k < 5; k++) i_src.frame(1'b0, 2'h0, 14'h0064, 14'h000a);
        rd_chk("flags", `BLM_OFS_FLAGS, 16'h0001);
        for (int k = 0; k < 7; k++) i_src.frame(1'b0, 2'h0, 14'h0064, 14'h000a);
        i_src.send(1'b0, 2'h0, 2'h0, 14'h0064, 14'h000a);
        settle();
        check("gpio1", {15'h0000, gpio1_alt}, 16'h0000);
        $display("test limit sixteen done");
        // Limit code zero never flags
        reg_write(`BLM_OFS_LIM_A, 16'h0059);
        for (int k = 0; k < 10; k++) i_src.frame(1'b0, 2'h1, 14'h0064, 14'h000a);
        settle();
        rd_chk("flags", `BLM_OFS_FLAGS, 16'h0000);
        $display("test limit never done");
        // Every select code on both pins, flag then interrupt only
        // Slot B threshold above slot A's: channel 2 sits on it, channel 1 passes it
        reg_write(`BLM_OFS_LIM_B, 16'h4060);
        i_src.send(1'b1, 2'h1, 2'h0, 14'h006a, 14'h000a);
        i_src.send(1'b1, 2'h0, 2'h0, 14'h0070, 14'h000a);
        for (int j = 0; j < 2; j++) begin
            for (int i = 0; i < 5; i++) begin
                reg_write(`BLM_OFS_PINSEL, {3'h0, codes[i], 3'h0, codes[i]});
                settle();
                check("gpio0", {15'h0000, gpio0_alt}, {15'h0000, exp_pin[j][i]});
                check("gpio1", {15'h0000, gpio1_alt}, {15'h0000, exp_pin[j][i]});
            end
            if (j == 0) begin
                rd_chk("flags", `BLM_OFS_FLAGS, 16'h0010);
                @(posedge clock);
                dev_int <= 1'b1;
            end
        end
        $display("test pin codes done");
        complete_run();
    end
endmodule

`default_nettype wire
